// ---- design/t16cs_params.svh ----
// Constants of the 16-bit timer control and status block.
// Assumes inclusion by bare name from design and bench files.
`ifndef T16CS_PARAMS_SVH
`define T16CS_PARAMS_SVH

// Register indices; byte address is four times the index
`define T16CS_IDX_CR1     6'h32
`define T16CS_IDX_CR2     6'h31
`define T16CS_IDX_CSR     6'h33
`define T16CS_IDX_IC1H    6'h34
`define T16CS_IDX_IC1L    6'h35
`define T16CS_IDX_OC1H    6'h36
`define T16CS_IDX_OC1L    6'h37
`define T16CS_IDX_CNTH    6'h38
`define T16CS_IDX_CNTL    6'h39
`define T16CS_IDX_ACNTH   6'h3a
`define T16CS_IDX_ACNTL   6'h3b
`define T16CS_IDX_IC2H    6'h3c
`define T16CS_IDX_IC2L    6'h3d
`define T16CS_IDX_OC2H    6'h3e
`define T16CS_IDX_OC2L    6'h3f

// First control register fields
`define T16CS_CR1_CAPIE   7
`define T16CS_CR1_CMPIE   6
`define T16CS_CR1_OVFIE   5
`define T16CS_CR1_FORCE2  4
`define T16CS_CR1_FORCE1  3
`define T16CS_CR1_LEVEL2  2
`define T16CS_CR1_EDGE1   1
`define T16CS_CR1_LEVEL1  0

// Second control register fields
`define T16CS_CR2_PIN1EN  7
`define T16CS_CR2_PIN2EN  6
`define T16CS_CR2_ONEP    5
`define T16CS_CR2_PWM     4
`define T16CS_CR2_CLKHI   3
`define T16CS_CR2_CLKLO   2
`define T16CS_CR2_EDGE2   1
`define T16CS_CR2_EXTEDG  0

// Status register fields
`define T16CS_SR_CAP1     7
`define T16CS_SR_CMP1     6
`define T16CS_SR_OVF      5
`define T16CS_SR_CAP2     4
`define T16CS_SR_CMP2     3
`define T16CS_SR_DIS      2
`define T16CS_SR_FLAGS    8'hf8

// Reset values
`define T16CS_CR1_RST     8'h00
`define T16CS_CR2_RST     8'h00
`define T16CS_SR_RST      8'h00
`define T16CS_OC_RST      16'h8000
`define T16CS_CNT_RST     16'hfffc
`define T16CS_CNT_MAX     16'hffff

// Prescaler terminal masks per clock selection
`define T16CS_CLK_DIV4    2'b00
`define T16CS_CLK_DIV2    2'b01
`define T16CS_CLK_DIV8    2'b10
`define T16CS_CLK_EXT     2'b11
`define T16CS_MASK_DIV4   3'h3
`define T16CS_MASK_DIV2   3'h1
`define T16CS_MASK_DIV8   3'h7

`endif

// ---- design/t16cs_pkg.sv ----
// Types of the 16-bit timer control and status block.
// Assumes t16cs_params.svh is compiled alongside.
package t16cs_pkg;

  // State of the timer top, apart from its three edge detectors
  typedef struct packed {
    logic [7:0]  cr1;
    logic [7:0]  cr2;
    logic [7:0]  sr;
    logic [7:0]  armed;
    logic [15:0] cnt;
    logic [2:0]  pre;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic        level1;
    logic        level2;
    logic        pulse_run;
    logic        pin1;
    logic        pin1_en;
    logic        pin2;
    logic        pin2_en;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [7:0]  prdata;
  } t16cs_state_s;

  // State of one edge detector
  typedef struct packed {
    logic prev;
    logic pulse;
  } t16cs_edge_s;

endpackage

// ---- design/t16cs_edge.sv ----
// Edge detector with selectable polarity, one-cycle registered pulse.
// Assumes its input is synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none

module t16cs_edge (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Signal and polarity
  input  wire logic sig_in,
  input  wire logic rise_sel,
  // Detected edge
  output var  logic edge_pulse
);

  t16cs_pkg::t16cs_edge_s st_reg;
  t16cs_pkg::t16cs_edge_s st_next;

  // Compare with previous sample
  always_comb begin
    st_next = st_reg;
    st_next.prev = sig_in;
    if (rise_sel) begin
      st_next.pulse = sig_in & ~st_reg.prev;
    end else begin
      st_next.pulse = ~sig_in & st_reg.prev;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign edge_pulse = st_reg.pulse;

endmodule

`default_nettype wire

// ---- design/t16cs_top.sv ----
// 16-bit timer control, status, counter and compare/capture logic.
// Assumes an APB master on pclk and pin inputs synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
`include "t16cs_params.svh"

module t16cs_top #(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Timer pins
  input  wire logic        capture1_input_pin,
  input  wire logic        capture2_input_pin,
  input  wire logic        external_count_input,
  output var  logic        compare1_output_pin,
  output var  logic        compare1_output_en,
  output var  logic        compare2_output_pin,
  output var  logic        compare2_output_en,
  // Interrupt
  output var  logic        timer_irq
);

  t16cs_pkg::t16cs_state_s st_reg;
  t16cs_pkg::t16cs_state_s st_next;

  logic [2:0] edge_in;
  logic [2:0] edge_pol;
  logic [2:0] edge_hit;

  // Edge polarity per input: capture1, capture2, external clock
  assign edge_in  = {external_count_input, capture2_input_pin,
                     capture1_input_pin};
  assign edge_pol = {st_reg.cr2[`T16CS_CR2_EXTEDG],
                     st_reg.cr2[`T16CS_CR2_EDGE2],
                     st_reg.cr1[`T16CS_CR1_EDGE1]};

  // One detector per edge input
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_edge
      t16cs_edge u_edge (
        .pclk       (pclk),
        .presetn    (presetn),
        .sig_in     (edge_in[gi]),
        .rise_sel   (edge_pol[gi]),
        .edge_pulse (edge_hit[gi])
      );
    end
  endgenerate

  // Address map check
  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx >= `T16CS_IDX_CR2) && (idx <= `T16CS_IDX_OC2L);
  endfunction

  // Read multiplexer
  function automatic logic [7:0] read_mux(
    input t16cs_pkg::t16cs_state_s s,
    input logic [5:0]              idx
  );
    read_mux = 8'h00;
    unique case (idx)
      `T16CS_IDX_CR1:   read_mux = s.cr1;
      `T16CS_IDX_CR2:   read_mux = s.cr2;
      `T16CS_IDX_CSR:   read_mux = s.sr;
      `T16CS_IDX_IC1H:  read_mux = s.cap1[15:8];
      `T16CS_IDX_IC1L:  read_mux = s.cap1[7:0];
      `T16CS_IDX_OC1H:  read_mux = s.cmp1[15:8];
      `T16CS_IDX_OC1L:  read_mux = s.cmp1[7:0];
      `T16CS_IDX_CNTH:  read_mux = s.cnt[15:8];
      `T16CS_IDX_CNTL:  read_mux = s.cnt[7:0];
      `T16CS_IDX_ACNTH: read_mux = s.cnt[15:8];
      `T16CS_IDX_ACNTL: read_mux = s.cnt[7:0];
      `T16CS_IDX_IC2H:  read_mux = s.cap2[15:8];
      `T16CS_IDX_IC2L:  read_mux = s.cap2[7:0];
      `T16CS_IDX_OC2H:  read_mux = s.cmp2[15:8];
      `T16CS_IDX_OC2L:  read_mux = s.cmp2[7:0];
      default:          read_mux = 8'h00;
    endcase
  endfunction

  // Next-state logic
  always_comb begin
    logic [5:0] idx;
    logic       done;
    logic       wr;
    logic       rd;
    logic       hit;
    logic       tick;
    logic       pwm_on;
    logic       onep_on;
    logic       enabled;
    logic       m1;
    logic       m2;
    logic       cap1_ev;
    logic [2:0] mask;
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic [7:0] wb;

    st_next = st_reg;
    idx     = paddr[7:2];
    done    = psel & penable & st_reg.pready;
    wr      = done & pwrite;
    rd      = done & ~pwrite;
    hit     = idx_mapped(idx);
    wb      = pwdata[7:0];
    pwm_on  = st_reg.cr2[`T16CS_CR2_PWM];
    onep_on = st_reg.cr2[`T16CS_CR2_ONEP] & ~pwm_on;
    enabled = ~st_reg.sr[`T16CS_SR_DIS];
    set_f   = 8'h00;
    clr_f   = 8'h00;
    mask    = `T16CS_MASK_DIV4;
    tick    = 1'b0;

    // Prescaler and count tick selection
    unique case (st_reg.cr2[`T16CS_CR2_CLKHI:`T16CS_CR2_CLKLO])
      `T16CS_CLK_DIV4: mask = `T16CS_MASK_DIV4;
      `T16CS_CLK_DIV2: mask = `T16CS_MASK_DIV2;
      `T16CS_CLK_DIV8: mask = `T16CS_MASK_DIV8;
      `T16CS_CLK_EXT:  mask = `T16CS_MASK_DIV4;
    endcase
    if (st_reg.cr2[`T16CS_CR2_CLKHI:`T16CS_CR2_CLKLO] == `T16CS_CLK_EXT) begin
      tick = enabled & HAS_EXT_CLK & edge_hit[2];
    end else begin
      tick = enabled & ((st_reg.pre & mask) == mask);
    end
    if (enabled) begin
      st_next.pre = st_reg.pre + 3'h1;
    end

    // Compare matches on each counted step
    m1      = tick && (st_reg.cnt == st_reg.cmp1);
    m2      = tick && (st_reg.cnt == st_reg.cmp2);
    cap1_ev = edge_hit[0];

    // Free-running counter with wrap detection
    if (tick) begin
      st_next.cnt = st_reg.cnt + 16'h0001;
      if (st_reg.cnt == `T16CS_CNT_MAX) begin
        set_f[`T16CS_SR_OVF] = 1'b1;
      end
    end

    // Mode dependent compare and capture behaviour
    if (pwm_on) begin
      if (m1) begin
        st_next.level1 = st_reg.cr1[`T16CS_CR1_LEVEL1];
      end
      if (m2) begin
        st_next.cnt    = `T16CS_CNT_RST;
        st_next.level1 = st_reg.cr1[`T16CS_CR1_LEVEL2];
        set_f[`T16CS_SR_CAP1] = 1'b1;
      end
    end else begin
      if (m1 && !onep_on) begin
        set_f[`T16CS_SR_CMP1] = 1'b1;
        st_next.level1 = st_reg.cr1[`T16CS_CR1_LEVEL1];
      end
      if (m2) begin
        set_f[`T16CS_SR_CMP2] = 1'b1;
        st_next.level2 = st_reg.cr1[`T16CS_CR1_LEVEL2];
      end
      if (cap1_ev) begin
        st_next.cap1 = st_reg.cnt;
        set_f[`T16CS_SR_CAP1] = 1'b1;
      end
    end

    // One-pulse sequence: start on capture1 edge, end on compare 1
    if (onep_on) begin
      if (m1 && st_reg.pulse_run) begin
        st_next.level1    = st_reg.cr1[`T16CS_CR1_LEVEL1];
        st_next.pulse_run = 1'b0;
      end
      if (cap1_ev) begin
        st_next.cnt       = `T16CS_CNT_RST;
        st_next.pre       = 3'h0;
        st_next.level1    = st_reg.cr1[`T16CS_CR1_LEVEL2];
        st_next.pulse_run = 1'b1;
      end
    end else begin
      st_next.pulse_run = 1'b0;
    end

    // Forced output levels
    if (st_reg.cr1[`T16CS_CR1_FORCE1]) begin
      st_next.level1 = st_reg.cr1[`T16CS_CR1_LEVEL1];
    end
    if (st_reg.cr1[`T16CS_CR1_FORCE2]) begin
      st_next.level2 = st_reg.cr1[`T16CS_CR1_LEVEL2];
    end

    // Capture 2 event
    if (edge_hit[1]) begin
      st_next.cap2 = st_reg.cnt;
      set_f[`T16CS_SR_CAP2] = 1'b1;
    end

    // Register writes, accepted even while disabled
    if (wr) begin
      unique case (idx)
        `T16CS_IDX_CR1:  st_next.cr1 = wb;
        `T16CS_IDX_CR2:  st_next.cr2 = wb;
        `T16CS_IDX_CSR:  st_next.sr[`T16CS_SR_DIS] = wb[`T16CS_SR_DIS];
        `T16CS_IDX_OC1H: st_next.cmp1[15:8] = wb;
        `T16CS_IDX_OC1L: st_next.cmp1[7:0]  = wb;
        `T16CS_IDX_OC2H: st_next.cmp2[15:8] = wb;
        `T16CS_IDX_OC2L: st_next.cmp2[7:0]  = wb;
        `T16CS_IDX_CNTL, `T16CS_IDX_ACNTL: begin
          st_next.cnt = `T16CS_CNT_RST;
          st_next.pre = 3'h0;
        end
        default: ;
      endcase
    end

    // Clear sequence: status read arms, low byte access other than ACNTL clears
    if (done) begin
      unique case (idx)
        `T16CS_IDX_IC1L: clr_f[`T16CS_SR_CAP1] = st_reg.armed[`T16CS_SR_CAP1];
        `T16CS_IDX_OC1L: clr_f[`T16CS_SR_CMP1] = st_reg.armed[`T16CS_SR_CMP1];
        `T16CS_IDX_CNTL: clr_f[`T16CS_SR_OVF]  = st_reg.armed[`T16CS_SR_OVF];
        `T16CS_IDX_IC2L: clr_f[`T16CS_SR_CAP2] = st_reg.armed[`T16CS_SR_CAP2];
        `T16CS_IDX_OC2L: clr_f[`T16CS_SR_CMP2] = st_reg.armed[`T16CS_SR_CMP2];
        default:         clr_f = 8'h00;
      endcase
    end
    st_next.armed = st_reg.armed & ~clr_f;
    if (rd && idx == `T16CS_IDX_CSR) begin
      st_next.armed = st_reg.sr & `T16CS_SR_FLAGS;
    end
    st_next.sr = (st_next.sr & ~clr_f) | set_f;
    st_next.sr[1:0] = 2'b00;

    // Pin outputs, gated by enables and disable bit
    st_next.pin1_en = st_next.cr2[`T16CS_CR2_PIN1EN] &
                      ~st_next.sr[`T16CS_SR_DIS];
    st_next.pin2_en = st_next.cr2[`T16CS_CR2_PIN2EN] &
                      ~st_next.sr[`T16CS_SR_DIS];
    st_next.pin1    = st_next.pin1_en & st_next.level1;
    st_next.pin2    = st_next.pin2_en & st_next.level2;

    // Shared interrupt line
    st_next.irq = (st_next.cr1[`T16CS_CR1_CAPIE] &
                   (st_next.sr[`T16CS_SR_CAP1] | st_next.sr[`T16CS_SR_CAP2]))
                | (st_next.cr1[`T16CS_CR1_CMPIE] &
                   (st_next.sr[`T16CS_SR_CMP1] | st_next.sr[`T16CS_SR_CMP2]))
                | (st_next.cr1[`T16CS_CR1_OVFIE] &
                   st_next.sr[`T16CS_SR_OVF]);

    // APB answer one cycle into the access phase
    if (psel && penable && !st_reg.pready) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = ~hit;
      st_next.prdata  = (hit && !pwrite) ? read_mux(st_reg, idx) : 8'h00;
    end else begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg           <= '0;
      st_reg.cr1       <= `T16CS_CR1_RST;
      st_reg.cr2       <= `T16CS_CR2_RST;
      st_reg.sr        <= `T16CS_SR_RST;
      st_reg.cnt       <= `T16CS_CNT_RST;
      st_reg.cmp1      <= `T16CS_OC_RST;
      st_reg.cmp2      <= `T16CS_OC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign prdata              = {24'h000000, st_reg.prdata};
  assign pready              = st_reg.pready;
  assign pslverr             = st_reg.pslverr;
  assign compare1_output_pin = st_reg.pin1;
  assign compare1_output_en  = st_reg.pin1_en;
  assign compare2_output_pin = st_reg.pin2;
  assign compare2_output_en  = st_reg.pin2_en;
  assign timer_irq           = st_reg.irq;

endmodule

`default_nettype wire

// ---- test/t16cs_top_properties.sv ----
// Port checker of the timer top: bus answers and pin gating.
// Assumes a bind from the bench onto t16cs_top.
`timescale 1ns/100ps
`default_nettype none
module t16cs_top_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        compare1_output_pin,
  input wire logic        compare1_output_en,
  input wire logic        compare2_output_pin,
  input wire logic        compare2_output_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // First access cycle, and a completed status read
  sequence s_start;
    psel && penable && !$past(penable);
  endsequence
  sequence s_stat_rd;
    pready && !pwrite && paddr[7:2] == 6'h33;
  endsequence
  a_ready_wait: assert property (s_start |=> pready)
    else $error("pready not after one wait state");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property ($rose(pready) |-> $past(penable) && psel)
    else $error("pready without access");
  a_err_only_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (pready && paddr[7:2] < 6'h31 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && paddr[7:2] >= 6'h31 |-> !pslverr)
    else $error("mapped access refused");
  a_reserved_zero: assert property (s_stat_rd |-> prdata[1:0] == 2'b00)
    else $error("reserved status bits not zero");
  a_disabled_pins: assert property (s_stat_rd ##0 prdata[2] |-> !compare1_output_en && !compare2_output_en)
    else $error("pins driven while disabled");
  a_pin1_gate: assert property (!compare1_output_en |-> !compare1_output_pin)
    else $error("pin 1 driven while not enabled");
  a_pin2_gate: assert property (!compare2_output_en |-> !compare2_output_pin)
    else $error("pin 2 driven while not enabled");
endmodule
`default_nettype wire

// ---- test/t16cs_top_tb.sv ----
// Self-checking APB bench of the timer top.
// Assumes design files and the checker file compile first.
`timescale 1ns/100ps
`default_nettype none
`include "t16cs_params.svh"
module t16cs_top_tb;
  // Bus, pins and bookkeeping
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        c1_in   = 1'b0;
  logic        c2_in   = 1'b0;
  logic        ext_in  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        o1;
  logic        o1_en;
  logic        o2;
  logic        o2_en;
  logic        irq;
  logic        perr;
  logic [7:0]  rdv;
  logic [7:0]  d;
  logic [7:0]  tk [3] = '{8'h10, 8'h20, 8'h08};
  int          h1;
  int          h2;
  int          p1;
  int          p2;
  int          fail_count   = 0;
  int          total_checks = 0;

  // Clock
  always #2.5 pclk = ~pclk;

  t16cs_top u_t16cs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture1_input_pin(c1_in),
    .capture2_input_pin(c2_in), .external_count_input(ext_in),
    .compare1_output_pin(o1), .compare1_output_en(o1_en),
    .compare2_output_pin(o2), .compare2_output_en(o2_en),
    .timer_irq(irq)
  );

  // Compare and count
  task automatic check(string nm, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic xfer(logic w, logic [5:0] i, logic [7:0] v);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rdv = prdata[7:0];
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [5:0] i, logic [7:0] v);
    xfer(1'b1, i, v);
  endtask

  task automatic rd(logic [5:0] i);
    xfer(1'b0, i, 8'h00);
  endtask

  // Read and compare masked bits
  task automatic rc(string nm, logic [5:0] i, logic [7:0] m, logic [7:0] e);
    rd(i);
    check(nm, rdv & m, e);
  endtask

  // Counter advance over 64 cycles, toggling the external input
  task automatic span(int tg);
    logic [7:0] a;
    rd(`T16CS_IDX_CNTL);
    a = rdv;
    for (int k = 0; k < 15; k++) begin
      if (k < tg) ext_in <= ~ext_in;
      repeat (4) @(posedge pclk);
    end
    rd(`T16CS_IDX_CNTL);
    d = rdv - a;
  endtask

  // Status read, then every low byte but ACNTL: clears all flags
  task automatic clr();
    rd(`T16CS_IDX_CSR);
    rd(`T16CS_IDX_IC1L);
    rd(`T16CS_IDX_OC1L);
    rd(`T16CS_IDX_CNTL);
    rd(`T16CS_IDX_IC2L);
    rd(`T16CS_IDX_OC2L);
  endtask

  // High time and period of pin 1, bounded at 300 cycles
  task automatic gap(output int h, output int p);
    int k;
    k = 0;
    while (o1 !== 1'b0 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    while (o1 !== 1'b1 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    h = 0;
    while (o1 === 1'b1 && h < 300) begin
      @(posedge pclk);
      h++;
    end
    p = h;
    while (o1 !== 1'b1 && p < 300) begin
      @(posedge pclk);
      p++;
    end
  endtask

  // Verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    complete_run();
  end

  // Test sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl2 reset", `T16CS_IDX_CR2, 8'hff, 8'h00);
    rc("disable reset", `T16CS_IDX_CSR, 8'h04, 8'h00);
    rd(6'h10);
    check("unmapped err", {7'h0, perr}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(`T16CS_IDX_CR2, {4'h0, i[1:0], 2'b00});
      span(0);
      check("prescale", d, tk[i]);
    end
    for (int e = 1; e >= 0; e--) begin
      wr(`T16CS_IDX_CR2, {7'h06, e[0]});
      span(9);
      check("ext edges", d, 8'h05);
    end
    wr(`T16CS_IDX_CSR, 8'h04);
    span(0);
    check("frozen", d, 8'h00);
    wr(`T16CS_IDX_CR2, 8'hd5);
    rc("ctrl2 rw", `T16CS_IDX_CR2, 8'hff, 8'hd5);
    check("pins off", {6'h0, o1_en, o2_en}, 8'h00);
    wr(`T16CS_IDX_CSR, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(`T16CS_IDX_CR1, {6'h00, s[0], 1'b0});
      wr(`T16CS_IDX_CR2, {6'h01, s[0], 1'b0});
      clr();
      c1_in <= 1'b1;
      c2_in <= 1'b1;
      repeat (6) @(posedge pclk);
      rc("cap rise", `T16CS_IDX_CSR, 8'h90, s ? 8'h90 : 8'h00);
      c1_in <= 1'b0;
      c2_in <= 1'b0;
      repeat (6) @(posedge pclk);
      rc("cap fall", `T16CS_IDX_CSR, 8'h90, 8'h90);
      rd(`T16CS_IDX_IC1L);
      rc("cap1 clear", `T16CS_IDX_CSR, 8'h90, 8'h10);
      rd(`T16CS_IDX_IC2L);
      rc("cap2 clear", `T16CS_IDX_CSR, 8'h90, 8'h00);
    end
    // Normal compare: both levels high, both pins enabled, div2
    wr(`T16CS_IDX_CR1, 8'h65);
    wr(`T16CS_IDX_OC1H, 8'h00);
    wr(`T16CS_IDX_OC1L, 8'h02);
    wr(`T16CS_IDX_OC2H, 8'h00);
    wr(`T16CS_IDX_OC2L, 8'h04);
    wr(`T16CS_IDX_CR2, 8'hc4);
    clr();
    wr(`T16CS_IDX_CNTL, 8'h00);
    repeat (40) @(posedge pclk);
    check("pins", {4'h0, o1, o1_en, o2, o2_en}, 8'h0f);
    check("irq", {7'h0, irq}, 8'h01);
    rc("flags", `T16CS_IDX_CSR, 8'hf8, 8'h68);
    rd(`T16CS_IDX_ACNTL);
    rc("ovf kept", `T16CS_IDX_CSR, 8'h20, 8'h20);
    rd(`T16CS_IDX_CNTL);
    wr(`T16CS_IDX_OC1L, 8'h02);
    rc("ovf cmp1 clear", `T16CS_IDX_CSR, 8'h68, 8'h08);
    // Pulse width: level2 high at reload, level1 low at compare 1
    wr(`T16CS_IDX_CR1, 8'h04);
    wr(`T16CS_IDX_OC1L, 8'h00);
    wr(`T16CS_IDX_CR2, 8'h94);
    wr(`T16CS_IDX_CNTL, 8'h00);
    gap(h1, p1);
    wr(`T16CS_IDX_OC2L, 8'h08);
    gap(h2, p2);
    check("pwm period", 8'(p2 - p1), 8'h08);
    check("pwm width", 8'(h2 - h1), 8'h00);
    rc("pwm cap1 flag", `T16CS_IDX_CSR, 8'h80, 8'h80);
    // One pulse on a rising capture 1 edge
    wr(`T16CS_IDX_CR1, 8'h06);
    wr(`T16CS_IDX_CR2, 8'ha4);
    wr(`T16CS_IDX_CNTL, 8'h00);
    repeat (20) @(posedge pclk);
    for (int w = 0; w < 2; w++) begin
      wr(`T16CS_IDX_OC1L, {5'h00, w[0], 2'b00});
      c1_in <= 1'b1;
      gap(h2, p2);
      c1_in <= 1'b0;
      if (w == 0) h1 = h2;
      check("single pulse", {7'h0, p2 == 300}, 8'h01);
    end
    check("pulse width", 8'(h2 - h1), 8'h08);
    complete_run();
  end
endmodule

bind t16cs_top t16cs_top_properties u_t16cs_top_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .compare1_output_pin(compare1_output_pin),
  .compare1_output_en(compare1_output_en),
  .compare2_output_pin(compare2_output_pin),
  .compare2_output_en(compare2_output_en)
);
`default_nettype wire
